// ===== hrs_map.svh
// register offsets, field positions and reset values of the return stack
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH
`define HRS_OFF_PTR      4'h0
`define HRS_OFF_TOS_LO   4'h1
`define HRS_OFF_TOS_HI   4'h2
`define HRS_OFF_FLAGS    4'h3
`define HRS_OFF_IRQ_EN   4'h4
`define HRS_PTR_RESET    5'h1f
`define HRS_EMPTY_ALIAS  4'he
`define HRS_BIT_OVF      0
`define HRS_BIT_UNF      1
`define HRS_BIT_FRE      7
`endif

// ===== hrs_pkg.sv
// types shared by the return stack files
`default_nettype none
package hrs_pkg;
   typedef enum logic [1:0] {
      HRS_OP_NONE = 2'b00,
      HRS_OP_PUSH = 2'b01,
      HRS_OP_POP  = 2'b10
   } hrs_op_t;
endpackage
`default_nettype wire

// ===== hrs_mem.sv
// entry storage of the return stack, registered read data
`default_nettype none
module hrs_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 15,
   parameter int AW    = 4
) (
   input  wire logic             clk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    waddr,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [AW-1:0]    raddr,
   output var  logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] cells [DEPTH];

   // no reset: storage contents are unknown at power up
   always_ff @(posedge clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (we && (waddr == raddr)) begin
         rdata <= wdata;
      end else begin
         rdata <= cells[raddr];
      end
   end
endmodule
`default_nettype wire

// ===== hrs_stack.sv
// hardware return-address stack with pointer, top-of-stack access and fault flags
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "hrs_map.svh"
`default_nettype none
module hrs_stack #(
   parameter int DEPTH = 16,
   parameter int PCW   = 15,
   parameter int PTRW  = 5
) (
   input  wire logic            clk,
   input  wire logic            nrst,
   input  wire logic            stack_fault_reset_enable,
   input  wire logic            push,
   input  wire logic            pop,
   input  wire logic [PCW-1:0]  pc_in,
   output var  logic [PCW-1:0]  pc_out,
   output var  logic            pc_out_valid,
   output var  logic            stack_fault_reset,
   input  wire logic [3:0]      addr,
   input  wire logic [7:0]      wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output var  logic [7:0]      rdata,
   output var  logic            irq
);
   localparam int AW = PTRW - 1;

   // ****************************************
   // state
   // ****************************************
   logic [PTRW-1:0]  stack_pointer_register;
   logic             stack_overflow_flag;
   logic             stack_underflow_flag;
   logic [1:0]       irq_mask;
   logic [PCW-1:0]   mem_rdata;
   logic [AW-1:0]    mem_raddr;
   logic [AW-1:0]    mem_waddr;
   logic [PCW-1:0]   mem_wdata;
   logic             mem_we;
   logic [PTRW-1:0]  next_ptr;
   logic             ovf_evt;
   logic             unf_evt;
   logic             sw_ptr_wr;
   logic             sw_lo_wr;
   logic             sw_hi_wr;
   logic             empty;
   logic [PCW-1:0]   top_of_stack_pair;
   logic [7:0]       top_of_stack_low;
   logic [7:0]       top_of_stack_high;
   logic             pop_q;
   hrs_pkg::hrs_op_t op;

   // ****************************************
   // sequencer requests
   // ****************************************
   // push or pop request, push wins
   always_comb begin
      if (push) begin
         op = hrs_pkg::HRS_OP_PUSH;
      end else if (pop) begin
         op = hrs_pkg::HRS_OP_POP;
      end else begin
         op = hrs_pkg::HRS_OP_NONE;
      end
   end

   assign sw_ptr_wr = wr && (addr == `HRS_OFF_PTR);
   assign sw_lo_wr  = wr && (addr == `HRS_OFF_TOS_LO);
   assign sw_hi_wr  = wr && (addr == `HRS_OFF_TOS_HI);

   always_comb begin
      next_ptr = stack_pointer_register;
      ovf_evt  = 1'b0;
      unf_evt  = 1'b0;
      case (op)
         hrs_pkg::HRS_OP_PUSH: begin
            if (stack_pointer_register == 5'h0f) begin
               ovf_evt  = 1'b1;
               next_ptr = 5'h00;
            end else begin
               next_ptr = stack_pointer_register + 5'h01;
            end
         end
         hrs_pkg::HRS_OP_POP: begin
            if (stack_pointer_register == `HRS_PTR_RESET) begin
               unf_evt  = 1'b1;
               next_ptr = 5'h0f;
            end else if (stack_pointer_register == 5'h00) begin
               next_ptr = `HRS_PTR_RESET;
            end else begin
               next_ptr = stack_pointer_register - 5'h01;
            end
         end
         default: begin
            next_ptr = stack_pointer_register;
         end
      endcase
   end

   // ****************************************
   // pointer
   // ****************************************
   // reset empty
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stack_pointer_register <= `HRS_PTR_RESET;
      end else if (op != hrs_pkg::HRS_OP_NONE) begin
         stack_pointer_register <= next_ptr;
      end else if (sw_ptr_wr) begin
         stack_pointer_register <= wdata[PTRW-1:0];
      end
   end

   // ****************************************
   // storage port
   // ****************************************
   assign empty = (stack_pointer_register == `HRS_PTR_RESET);

   always_comb begin
      if (op != hrs_pkg::HRS_OP_NONE) begin
         mem_raddr = next_ptr[AW-1:0];
      end else if (sw_ptr_wr) begin
         // a pointer written to empty must show the alias entry at once
         if (wdata[PTRW-1:0] == `HRS_PTR_RESET) begin
            mem_raddr = `HRS_EMPTY_ALIAS;
         end else begin
            mem_raddr = wdata[AW-1:0];
         end
      end else if (empty) begin
         mem_raddr = `HRS_EMPTY_ALIAS;
      end else begin
         mem_raddr = stack_pointer_register[AW-1:0];
      end
      if (op == hrs_pkg::HRS_OP_POP && next_ptr == `HRS_PTR_RESET) begin
         mem_raddr = `HRS_EMPTY_ALIAS;
      end
   end

   always_comb begin
      mem_we    = 1'b0;
      mem_waddr = stack_pointer_register[AW-1:0];
      mem_wdata = top_of_stack_pair;
      if (op == hrs_pkg::HRS_OP_PUSH) begin
         mem_we    = 1'b1;
         mem_waddr = next_ptr[AW-1:0];
         mem_wdata = pc_in;
      end else if ((sw_lo_wr || sw_hi_wr) && !empty) begin
         mem_we = 1'b1;
         if (sw_lo_wr) begin
            mem_wdata = {top_of_stack_pair[PCW-1:8], wdata};
         end else begin
            mem_wdata = {wdata[PCW-9:0], top_of_stack_pair[7:0]};
         end
      end
   end

   hrs_mem #(
      .DEPTH (DEPTH),
      .WIDTH (PCW),
      .AW    (AW)
   ) u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (mem_raddr),
      .rdata (mem_rdata)
   );

   // ****************************************
   // top of stack view
   // ****************************************
   // zero when guarded and empty
   always_comb begin
      if (empty && stack_fault_reset_enable) begin
         top_of_stack_pair = '0;
      end else begin
         top_of_stack_pair = mem_rdata;
      end
   end

   assign top_of_stack_low  = top_of_stack_pair[7:0];
   assign top_of_stack_high = {1'b0, top_of_stack_pair[PCW-1:8]};

   // ****************************************
   // return path
   // ****************************************
   // entry is read before the pointer moves, so the value leaving is the one popped
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pop_q <= 1'b0;
      end else begin
         pop_q <= (op == hrs_pkg::HRS_OP_POP);
      end
   end

   assign pc_out_valid = pop_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pc_out <= '0;
      end else begin
         if (op == hrs_pkg::HRS_OP_POP) begin
            pc_out <= top_of_stack_pair;
         end
      end
   end

   // ****************************************
   // fault flags
   // ****************************************
   // flags set regardless of mode
   // set wins over a software write-one clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stack_overflow_flag  <= 1'b0;
         stack_underflow_flag <= 1'b0;
      end else begin
         if (ovf_evt) begin
            stack_overflow_flag <= 1'b1;
         end else if (wr && addr == `HRS_OFF_FLAGS && wdata[`HRS_BIT_OVF]) begin
            stack_overflow_flag <= 1'b0;
         end
         if (unf_evt) begin
            stack_underflow_flag <= 1'b1;
         end else if (wr && addr == `HRS_OFF_FLAGS && wdata[`HRS_BIT_UNF]) begin
            stack_underflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stack_fault_reset <= 1'b0;
      end else begin
         stack_fault_reset <= stack_fault_reset_enable && (ovf_evt || unf_evt);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_mask <= 2'h0;
      end else if (wr && addr == `HRS_OFF_IRQ_EN) begin
         irq_mask <= wdata[1:0];
      end
   end

   assign irq = |({stack_underflow_flag, stack_overflow_flag} & irq_mask);

   // ****************************************
   // register reads
   // ****************************************
   // software reads
   // software must mask interrupts around pointer edits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `HRS_OFF_PTR:    rdata <= {3'h0, stack_pointer_register};
            `HRS_OFF_TOS_LO: rdata <= top_of_stack_low;
            `HRS_OFF_TOS_HI: rdata <= top_of_stack_high;
            `HRS_OFF_FLAGS:  rdata <= {stack_fault_reset_enable, 5'h00,
                                       stack_underflow_flag, stack_overflow_flag};
            `HRS_OFF_IRQ_EN: rdata <= {6'h00, irq_mask};
            default:         rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ===== hrs_stack_assertions.sv
// port assertions of the return stack
`default_nettype none
module hrs_stack_assertions (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       stack_fault_reset_enable,
   input wire logic       push,
   input wire logic       pop,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       pc_out_valid,
   input wire logic       stack_fault_reset,
   input wire logic       irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ********
   // checks
   // ********
   a_pop_gives_valid: assert property (pop && !push |=> pc_out_valid)
      else $error("no valid after pop");
   a_valid_has_pop: assert property (pc_out_valid |-> $past(pop) && !$past(push))
      else $error("stray valid");
   a_fault_has_op: assert property (
      stack_fault_reset |-> $past(stack_fault_reset_enable) && ($past(push) || $past(pop)))
      else $error("stray fault reset");
   a_fault_one_cycle: assert property (stack_fault_reset |=> !stack_fault_reset)
      else $error("fault reset too long");
   a_ring_no_fault: assert property (
      !stack_fault_reset_enable ##1 !stack_fault_reset_enable |-> !stack_fault_reset)
      else $error("fault reset while off");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data without read");
   a_irq_cause: assert property ($rose(irq) |-> $past(push) || $past(pop) || $past(wr))
      else $error("irq rose without cause");
   a_reset_quiet: assert property ($rose(nrst) |-> !pc_out_valid && !stack_fault_reset && !irq)
      else $error("outputs busy after reset");
   c_pop: cover property (pop ##1 pc_out_valid);
   c_fault: cover property (stack_fault_reset);
   c_irq: cover property ($rose(irq));
endmodule
bind hrs_stack hrs_stack_assertions i_hrs_stack_assertions (.clk(clk), .nrst(nrst),
   .stack_fault_reset_enable(stack_fault_reset_enable), .push(push), .pop(pop), .wr(wr), .rd(rd),
   .rdata(rdata), .pc_out_valid(pc_out_valid), .stack_fault_reset(stack_fault_reset), .irq(irq));
`default_nettype wire

// ===== hrs_seq_model.sv
// core sequencer model issuing push and pop pulses
`default_nettype none
module hrs_seq_model (
   input  wire logic        clk,
   input  wire logic [14:0] pc_out,
   input  wire logic        pc_out_valid,
   input  wire logic        stack_fault_reset,
   output var  logic        push,
   output var  logic        pop,
   output var  logic [14:0] pc_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [14:0] got;
   logic        vld;
   logic        flt;
   // *********
   // requests
   // *********
   initial begin
      push = 1'b0;
      pop = 1'b0;
      pc_in = 15'h0;
   end
   task automatic op(input logic p, input logic [14:0] v);
      @(posedge clk);
      push <= p;
      pop <= !p;
      pc_in <= v;
      @(posedge clk);
      push <= 1'b0;
      pop <= 1'b0;
      // stale pc must not look valid
      pc_in <= ~v;
      @(posedge clk);
      got = pc_out;
      vld = pc_out_valid;
      flt = stack_fault_reset;
   endtask
endmodule
`default_nettype wire

// ===== hrs_stack_tb_top.sv
// bench comparing the return stack with an integer model
`default_nettype none
module hrs_stack_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, nrst, fre, wr, rd, push, pop, pcv, frst, irq;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, v;
   logic [14:0] pc_in, pc_out;
   int          fail_count, n_tests, cyc, seed, ptr, flg, i;
   int          mem [16];
   hrs_stack i_hrs_stack (.clk(clk), .nrst(nrst), .stack_fault_reset_enable(fre), .push(push),
      .pop(pop), .pc_in(pc_in), .pc_out(pc_out), .pc_out_valid(pcv), .stack_fault_reset(frst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   hrs_seq_model i_hrs_seq_model (.clk(clk), .pc_out(pc_out), .pc_out_valid(pcv),
      .stack_fault_reset(frst), .push(push), .pop(pop), .pc_in(pc_in));
   // ******
   // tasks
   // ******
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask
   task automatic chk_ptr;
      rd_reg(4'h0);
      chk("ptr", 16'(v), 16'(ptr));
   endtask
   task automatic do_push(input logic [14:0] p);
      i_hrs_seq_model.op(1'b1, p);
      chk("fault", 16'(i_hrs_seq_model.flt), 16'(fre && ptr == 15));
      if (ptr == 15) flg |= 1;
      ptr = (ptr == 15) ? 0 : (ptr + 1) % 32;
      mem[ptr] = 32'(p);
   endtask
   task automatic do_pop;
      i_hrs_seq_model.op(1'b0, 15'h0);
      chk("fault", 16'(i_hrs_seq_model.flt), 16'(fre && ptr == 31));
      chk("valid", 16'(i_hrs_seq_model.vld), 16'h1);
      if (ptr == 31) begin
         flg |= 2;
         ptr = 15;
      end else begin
         chk("pc", 16'(i_hrs_seq_model.got), 16'(mem[ptr]));
         ptr = (ptr == 0) ? 31 : ptr - 1;
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // *********
   // sequence
   // *********
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard, far above the fewer than two hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      seed = 32'h7dae41c8;
      {nrst, fre, wr, rd, addr, wdata} = '0;
      ptr = 31;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      chk_ptr();
      rd_reg(4'h3);
      chk("flags", 16'(v), 16'h0);
      $display("reset test done");
      for (i = 0; i < 17; i++) do_push(15'($random(seed)));
      chk_ptr();
      rd_reg(4'h3);
      chk("flags", 16'(v), 16'(flg));
      chk("irq", 16'(irq), 16'h0);
      wr_reg(4'h4, 8'h03);
      rd_reg(4'h3);
      chk("irq", 16'(irq), 16'h1);
      wr_reg(4'h3, 8'h01);
      rd_reg(4'h3);
      flg = 0;
      chk("flags", 16'(v), 16'h0);
      chk("irq", 16'(irq), 16'h0);
      // select the entry, then touch the pair
      wr_reg(4'h0, 8'h05);
      ptr = 5;
      rd_reg(4'h1);
      chk("tos_lo", 16'(v), 16'(mem[5][7:0]));
      rd_reg(4'h2);
      chk("tos_hi", 16'(v), 16'(mem[5][14:8]));
      mem[5] = $random(seed) & 32'h7fff;
      wr_reg(4'h1, mem[5][7:0]);
      wr_reg(4'h2, mem[5][15:8]);
      for (i = 0; i < 7; i++) do_pop();
      chk_ptr();
      rd_reg(4'h3);
      chk("flags", 16'(v), 16'(flg));
      wr_reg(4'h0, 8'h1f);
      ptr = 31;
      rd_reg(4'h1);
      chk("tos_lo", 16'(v), 16'(mem[14][7:0]));
      $display("ring test done");
      fre <= 1'b1;
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      flg = 0;
      rd_reg(4'h1);
      chk("tos_lo", 16'(v), 16'h0);
      rd_reg(4'h3);
      chk("flags", 16'(v), 16'h80);
      rd_reg(4'h2);
      chk("tos_hi", 16'(v), 16'h0);
      do_pop();
      do_push(15'h7fff);
      chk_ptr();
      rd_reg(4'h3);
      chk("flags", 16'(v), 16'(flg | 32'h80));
      $display("fault test done");
      complete_run();
   end
endmodule
`default_nettype wire
